// ---- pkg/kbp_pkg.sv ----
package kbp_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int KBP_NPORT = 4;
  localparam int KBP_PW = 8;
  localparam int KBP_NPIN = 31;
  localparam int KBP_PA = 0;
  localparam int KBP_PB = 1;
  localparam int KBP_PC = 2;
  localparam int KBP_PD = 3;
  localparam logic [7:0] KBP_PC_MASK = 8'h7F;
  localparam logic [7:0] KBP_BYTE_MASK = 8'hFF;
  // Flat pin vector: a = 0..7, b = 8..15, c = 16..22, d = 23..30
  localparam int KBP_BASE_D = 23;
  localparam int KBP_C_SCK = 16;
  localparam int KBP_C_SO = 17;
  localparam int KBP_C_SI = 18;
  localparam int KBP_C_P5 = 21;
  localparam int KBP_C_P6 = 22;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] KBP_OFF_DATA = 12'h000;
  localparam logic [11:0] KBP_OFF_DIR = 12'h010;
  localparam logic [11:0] KBP_OFF_PU = 12'h020;
  localparam logic [11:0] KBP_OFF_OD = 12'h030;
  localparam logic [11:0] KBP_OFF_FUNC = 12'h034;
  localparam logic [11:0] KBP_OFF_ISTAT = 12'h038;
  localparam logic [11:0] KBP_OFF_IMASK = 12'h03C;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int KBP_OD_A = 0;
  localparam int KBP_OD_B = 1;
  localparam int KBP_OD_C5 = 2;
  localparam int KBP_OD_C6 = 3;
  localparam int KBP_FN_SER = 0;
  localparam int KBP_FN_TMO = 1;
  localparam int KBP_FN_EDGE = 2;
  localparam int KBP_IS_EXT = 0;
  localparam int KBP_IS_KEY = 1;
  localparam logic [7:0] KBP_RST_BYTE = 8'h00;
  localparam logic [3:0] KBP_RST_NIB = 4'h0;
  localparam logic [1:0] KBP_RST_IS = 2'h0;
  typedef enum logic [1:0] {
    KBP_EDGE_NONE, KBP_EDGE_RISE, KBP_EDGE_FALL, KBP_EDGE_BOTH
  } kbp_edge_e;
  typedef logic [7:0] kbp_byte_t;
endpackage

// ---- pkg/kbp_sync_if.sv ----
`timescale 1ns/100ps
interface kbp_sync_if #(parameter int W = 31);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// ---- hw/kbp_pin_sync.sv ----
`timescale 1ns/100ps
module kbp_pin_sync #(
  parameter int W = 31
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] raw,
  kbp_sync_if.src sif
);
  if (W < 1) begin : g_bad_w
    $error("kbp_pin_sync: width must be positive");
  end

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // Pins are asynchronous; only sync_r looks at meta_r
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else if (ce) begin
      meta_r <= raw;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign sif.lvl = sync_r;
  assign sif.rise = sync_r & ~prev_r;
  assign sif.fall = ~sync_r & prev_r;
endmodule // kbp_pin_sync

// ---- hw/kbp_port_top.sv ----
// What this block does
// - Each pin independently set input or output
// - Pull-up selectable per pin, only as input
// - Ports a, b: one open-drain choice per port
// - Port c pins 5, 6: own open-drain choice
// - Three 8-bit, one 7-bit port; inputs at reset
// - External interrupt on rising, falling or both
// - Port d pins detect key-return activity
// - Port c pins 0-2 carry serial clock, out, in
// - Port c pin 6 shares irq, timer in, out
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module kbp_port_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [kbp_pkg::KBP_PW-1:0] port_a_pins_i,
  output logic [kbp_pkg::KBP_PW-1:0] port_a_pins_o,
  output logic [kbp_pkg::KBP_PW-1:0] port_a_pins_oe,
  output logic [kbp_pkg::KBP_PW-1:0] port_a_pins_pu,
  input wire logic [kbp_pkg::KBP_PW-1:0] port_b_pins_i,
  output logic [kbp_pkg::KBP_PW-1:0] port_b_pins_o,
  output logic [kbp_pkg::KBP_PW-1:0] port_b_pins_oe,
  output logic [kbp_pkg::KBP_PW-1:0] port_b_pins_pu,
  input wire logic [6:0] port_c_pins_i,
  output logic [6:0] port_c_pins_o,
  output logic [6:0] port_c_pins_oe,
  output logic [6:0] port_c_pins_pu,
  input wire logic [kbp_pkg::KBP_PW-1:0] port_d_pins_i,
  output logic [kbp_pkg::KBP_PW-1:0] port_d_pins_o,
  output logic [kbp_pkg::KBP_PW-1:0] port_d_pins_oe,
  output logic [kbp_pkg::KBP_PW-1:0] port_d_pins_pu,
  output logic [kbp_pkg::KBP_PW-1:0] key_return_inputs,
  output logic ser_clk_i,
  input wire logic ser_clk_o,
  input wire logic ser_clk_oe,
  input wire logic ser_dout,
  output logic ser_din,
  output logic tmr_count_in,
  input wire logic tmr_out,
  output logic irq
);
  import kbp_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  kbp_byte_t lat_r [KBP_NPORT];
  kbp_byte_t dir_r [KBP_NPORT];
  kbp_byte_t pu_r [KBP_NPORT];
  logic [3:0] od_r;
  logic [3:0] func_r;
  logic [1:0] istat_r;
  logic [1:0] imask_r;
  logic cap_r, slverr_r;
  logic [31:0] prdata_r;

  kbp_sync_if #(.W(KBP_NPIN)) sif ();

  kbp_pin_sync #(.W(KBP_NPIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .raw({port_d_pins_i, port_c_pins_i, port_b_pins_i, port_a_pins_i}),
    .sif(sif.src)
  );

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic wr_en, aligned, hit;
  logic [1:0] idx;
  logic [7:0] grp;
  kbp_byte_t msk;
  logic [31:0] rd_val;
  kbp_byte_t in_byte [KBP_NPORT];
  kbp_byte_t view [KBP_NPORT];

  // A late clock enable must not let a stale snapshot be answered
  assign pready = ce & cap_r;
  assign wr_en = psel & penable & pwrite & pready;
  assign idx = paddr[3:2];
  assign grp = paddr[11:4];
  assign aligned = (paddr[1:0] == 2'h0);
  assign msk = (idx == 2'(KBP_PC)) ? KBP_PC_MASK : KBP_BYTE_MASK;
  assign prdata = prdata_r;
  assign pslverr = slverr_r;

  always_comb begin
    in_byte[KBP_PA] = sif.lvl[7:0];
    in_byte[KBP_PB] = sif.lvl[15:8];
    in_byte[KBP_PC] = {1'b0, sif.lvl[22:16]};
    in_byte[KBP_PD] = sif.lvl[30:23];
    for (int p = 0; p < KBP_NPORT; p++) begin
      view[p] = (dir_r[p] & lat_r[p]) | (~dir_r[p] & in_byte[p]);
    end
  end

  always_comb begin
    rd_val = '0;
    hit = aligned;
    case (grp)
      KBP_OFF_DATA[11:4]: rd_val[7:0] = view[idx];
      KBP_OFF_DIR[11:4]: rd_val[7:0] = dir_r[idx];
      KBP_OFF_PU[11:4]: rd_val[7:0] = pu_r[idx];
      default: begin
        case (paddr)
          KBP_OFF_OD: rd_val[3:0] = od_r;
          KBP_OFF_FUNC: rd_val[3:0] = func_r;
          KBP_OFF_ISTAT: rd_val[1:0] = istat_r;
          KBP_OFF_IMASK: rd_val[1:0] = imask_r;
          default: hit = 1'b0;
        endcase
      end
    endcase
  end

  // Snapshot at the first enabled edge so a frozen setup cannot hang
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_r <= 1'b0;
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else if (ce) begin
      if (psel && !cap_r) begin
        cap_r <= 1'b1;
        prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
        slverr_r <= ~hit;
      end else if (psel && penable && cap_r) begin
        cap_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Port registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < KBP_NPORT; p++) begin
        lat_r[p] <= KBP_RST_BYTE;
        dir_r[p] <= KBP_RST_BYTE;
        pu_r[p] <= KBP_RST_BYTE;
      end
    end else if (ce && wr_en && aligned) begin
      if (grp == KBP_OFF_DATA[11:4]) lat_r[idx] <= pwdata[7:0] & msk;
      if (grp == KBP_OFF_DIR[11:4]) dir_r[idx] <= pwdata[7:0] & msk;
      if (grp == KBP_OFF_PU[11:4]) pu_r[idx] <= pwdata[7:0] & msk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      od_r <= KBP_RST_NIB;
      func_r <= KBP_RST_NIB;
      imask_r <= KBP_RST_IS;
    end else if (ce && wr_en) begin
      if (paddr == KBP_OFF_OD) od_r <= pwdata[3:0];
      if (paddr == KBP_OFF_FUNC) func_r <= pwdata[3:0];
      if (paddr == KBP_OFF_IMASK) imask_r <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic [KBP_NPIN-1:0] dir_f, lat_f, pu_f, od_f;
  logic [KBP_NPIN-1:0] fn_en, fn_oe, fn_val;
  logic [KBP_NPIN-1:0] want_oe, pin_val, pin_oe, pin_pu;

  assign dir_f = {dir_r[3], dir_r[2][6:0], dir_r[1], dir_r[0]};
  assign lat_f = {lat_r[3], lat_r[2][6:0], lat_r[1], lat_r[0]};
  assign pu_f = {pu_r[3], pu_r[2][6:0], pu_r[1], pu_r[0]};

  assign od_f = {8'h00, od_r[KBP_OD_C6], od_r[KBP_OD_C5], 5'h00,
    {8{od_r[KBP_OD_B]}}, {8{od_r[KBP_OD_A]}}};

  // Alternate functions take the pin over from the port latch
  always_comb begin
    fn_en = '0;
    fn_oe = '0;
    fn_val = '0;
    if (func_r[KBP_FN_SER]) begin
      fn_en[KBP_C_SCK] = 1'b1;
      fn_oe[KBP_C_SCK] = ser_clk_oe;
      fn_val[KBP_C_SCK] = ser_clk_o;
      fn_en[KBP_C_SO] = 1'b1;
      fn_oe[KBP_C_SO] = 1'b1;
      fn_val[KBP_C_SO] = ser_dout;
      fn_en[KBP_C_SI] = 1'b1;
    end
    if (func_r[KBP_FN_TMO]) begin
      fn_en[KBP_C_P6] = 1'b1;
      fn_oe[KBP_C_P6] = 1'b1;
      fn_val[KBP_C_P6] = tmr_out;
    end
  end

  for (genvar i = 0; i < KBP_NPIN; i++) begin : g_pin
    assign want_oe[i] = fn_en[i] ? fn_oe[i] : dir_f[i];
    assign pin_val[i] = fn_en[i] ? fn_val[i] : lat_f[i];
    // Open-drain drives only the low level
    assign pin_oe[i] = want_oe[i] & ~(od_f[i] & pin_val[i]);
    assign pin_pu[i] = ~want_oe[i] & pu_f[i];
  end

  assign {port_d_pins_o, port_c_pins_o, port_b_pins_o,
    port_a_pins_o} = pin_val;
  assign {port_d_pins_oe, port_c_pins_oe, port_b_pins_oe,
    port_a_pins_oe} = pin_oe;
  assign {port_d_pins_pu, port_c_pins_pu, port_b_pins_pu,
    port_a_pins_pu} = pin_pu;
  assign key_return_inputs = sif.lvl[30:23];
  assign ser_clk_i = sif.lvl[KBP_C_SCK];
  assign ser_din = sif.lvl[KBP_C_SI];
  assign tmr_count_in = sif.lvl[KBP_C_P6];

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  kbp_edge_e edge_sel;
  logic ext_ev, key_ev;
  logic [1:0] is_clr, is_set;

  assign edge_sel = kbp_edge_e'(func_r[KBP_FN_EDGE+1:KBP_FN_EDGE]);

  always_comb begin
    case (edge_sel)
      KBP_EDGE_RISE: ext_ev = sif.rise[KBP_C_P6];
      KBP_EDGE_FALL: ext_ev = sif.fall[KBP_C_P6];
      KBP_EDGE_BOTH: ext_ev = sif.rise[KBP_C_P6] | sif.fall[KBP_C_P6];
      default: ext_ev = 1'b0;
    endcase
    ext_ev = ext_ev & ~want_oe[KBP_C_P6];
  end

  // A key press pulls a return line low; driven lines are ignored
  assign key_ev = |(sif.fall[30:23] & ~want_oe[30:23]);
  assign is_set = {key_ev, ext_ev};
  assign is_clr = (wr_en && paddr == KBP_OFF_ISTAT) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= KBP_RST_IS;
    end else if (ce) begin
      istat_r <= (istat_r & ~is_clr) | is_set;
    end
  end

  assign irq = |(istat_r & imask_r);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_dir_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == KBP_OFF_DIR) |=> dir_r[KBP_PA] == $past(pwdata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not applied");

  property p_pu_input;
    @(posedge pclk) disable iff (!presetn)
    port_a_pins_pu == (pu_r[KBP_PA] & ~dir_r[KBP_PA]);
  endproperty
  a_pu_input: assert property (p_pu_input)
    else $error("pull-up on while pin drives");

  property p_od_port;
    @(posedge pclk) disable iff (!presetn)
    od_r[KBP_OD_A] |-> (port_a_pins_oe & port_a_pins_o) == 8'h00;
  endproperty
  a_od_port: assert property (p_od_port)
    else $error("open-drain port a drives high");

  property p_od_pin5;
    @(posedge pclk) disable iff (!presetn)
    port_c_pins_oe[5] == (dir_r[KBP_PC][5]
      && !(od_r[KBP_OD_C5] && lat_r[KBP_PC][5]));
  endproperty
  a_od_pin5: assert property (p_od_pin5)
    else $error("port c pin 5 drive wrong");

  property p_reset_inputs;
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (pin_oe == '0 && irq == 1'b0);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("pin driven right after reset");

  property p_ext_rise;
    @(posedge pclk) disable iff (!presetn)
    (ce && edge_sel == KBP_EDGE_RISE && sif.rise[KBP_C_P6]
      && !want_oe[KBP_C_P6]) |=> istat_r[KBP_IS_EXT];
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("rising edge interrupt missed");

  property p_key_set;
    @(posedge pclk) disable iff (!presetn)
    (ce && key_ev) |=> istat_r[KBP_IS_KEY] ##1 istat_r[KBP_IS_KEY]
      || $past(is_clr[KBP_IS_KEY]);
  endproperty
  a_key_set: assert property (p_key_set)
    else $error("key return event lost");

  property p_ser_out;
    @(posedge pclk) disable iff (!presetn)
    func_r[KBP_FN_SER] |-> (port_c_pins_o[1] == ser_dout
      && port_c_pins_oe[2] == 1'b0);
  endproperty
  a_ser_out: assert property (p_ser_out)
    else $error("serial pins not routed");

  property p_tmr_out;
    @(posedge pclk) disable iff (!presetn)
    (func_r[KBP_FN_TMO] && !od_r[KBP_OD_C6]) |->
      (port_c_pins_oe[6] && port_c_pins_o[6] == tmr_out);
  endproperty
  a_tmr_out: assert property (p_tmr_out)
    else $error("timer output not on pin");

  property p_read_latch;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == KBP_OFF_DATA
      && $stable(dir_r[KBP_PA]) && $stable(lat_r[KBP_PA]))
      |-> (prdata[7:0] & dir_r[KBP_PA]) == (lat_r[KBP_PA] & dir_r[KBP_PA]);
  endproperty
  a_read_latch: assert property (p_read_latch)
    else $error("output port read not latch");
endmodule // kbp_port_top

// ---- tb/kbp_pin_model.sv ----
`timescale 1ns/100ps
module kbp_pin_model #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic [W-1:0] o,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pu,
  input wire logic [W-1:0] ext,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] lvl
);
  // A line nobody holds toggles each cycle so no stale level survives
  logic [W-1:0] flt_r = '0;
  always_ff @(posedge pclk) begin
    flt_r <= ~flt_r;
  end
  // ---------------------------------------------------------------
  // Wire resolution: device drive wins, then far side, then pull-up
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl[i] = oe[i] ? o[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 : flt_r[i];
    end
  end
endmodule // kbp_pin_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb;
  import kbp_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ser_clk_i, ser_din, tmr_count_in, irq;
  logic ser_clk_o = 1'b0, ser_clk_oe = 1'b0, ser_dout = 1'b0;
  logic tmr_out = 1'b0;
  logic [7:0] a_o, a_oe, a_pu, b_o, b_oe, b_pu, d_o, d_oe, d_pu, keys;
  logic [6:0] c_o, c_oe, c_pu, lvl_c;
  logic [7:0] lvl_a, lvl_b, lvl_d;
  logic [7:0] ext_a = 8'h3C, ext_b = 8'h00, ext_d = 8'hFF, en_a = 8'hFF;
  logic [6:0] ext_c = 7'h00;
  int mismatches = 0, check_count = 0, cyc = 0;
  kbp_port_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_pins_i(lvl_a), .port_a_pins_o(a_o), .port_a_pins_oe(a_oe),
    .port_a_pins_pu(a_pu), .port_b_pins_i(lvl_b), .port_b_pins_o(b_o),
    .port_b_pins_oe(b_oe), .port_b_pins_pu(b_pu), .port_c_pins_i(lvl_c),
    .port_c_pins_o(c_o), .port_c_pins_oe(c_oe), .port_c_pins_pu(c_pu),
    .port_d_pins_i(lvl_d), .port_d_pins_o(d_o), .port_d_pins_oe(d_oe),
    .port_d_pins_pu(d_pu), .key_return_inputs(keys),
    .ser_clk_i(ser_clk_i), .ser_clk_o(ser_clk_o), .ser_clk_oe(ser_clk_oe),
    .ser_dout(ser_dout), .ser_din(ser_din), .tmr_count_in(tmr_count_in),
    .tmr_out(tmr_out), .irq(irq));
  kbp_pin_model #(.W(8)) u_pa (.pclk(pclk), .o(a_o), .oe(a_oe),
    .pu(a_pu), .ext(ext_a), .ext_en(en_a), .lvl(lvl_a));
  kbp_pin_model #(.W(8)) u_pb (.pclk(pclk), .o(b_o), .oe(b_oe),
    .pu(b_pu), .ext(ext_b), .ext_en(8'hFF), .lvl(lvl_b));
  kbp_pin_model #(.W(7)) u_pc (.pclk(pclk), .o(c_o), .oe(c_oe),
    .pu(c_pu), .ext(ext_c), .ext_en(7'h7F), .lvl(lvl_c));
  kbp_pin_model #(.W(8)) u_pd (.pclk(pclk), .o(d_o), .oe(d_oe),
    .pu(d_pu), .ext(ext_d), .ext_en(8'hFF), .lvl(lvl_d));
  initial begin
    forever #2 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write land before the caller looks at the pins
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic settle();
    repeat (5) @(posedge pclk);
  endtask
  // Bounded run: the sequence needs well under 2000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 4; i < 16; i++) rd(12'(i * 4), 32'h0);
    chk({a_oe, b_oe, d_oe, 1'b0, c_oe}, 32'h0);
    ce <= 1'b0;
    fork
      wr(KBP_OFF_DIR + 12'h4, 32'h01);
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    chk(b_oe, 32'h01);
    wr(KBP_OFF_DATA, 32'hA5);
    wr(KBP_OFF_DIR, 32'h0F);
    settle();
    chk({a_oe, a_o[3:0]}, 32'hF5);
    rd(KBP_OFF_DATA, 32'h35);
    en_a <= 8'h0F;
    wr(KBP_OFF_PU, 32'hFF);
    settle();
    chk(a_pu, 32'hF0);
    rd(KBP_OFF_DATA, 32'hF5);
    wr(KBP_OFF_DATA + 12'h4, 32'h0F);
    wr(KBP_OFF_DIR + 12'h4, 32'hFF);
    wr(KBP_OFF_OD, 32'h3);
    chk({a_oe, b_oe}, 32'h0AF0);
    wr(KBP_OFF_DATA + 12'h8, 32'hE0);
    wr(KBP_OFF_DIR + 12'h8, 32'h7F);
    wr(KBP_OFF_OD, 32'h4);
    chk(c_oe, 32'h5F);
    wr(KBP_OFF_OD, 32'hC);
    chk(c_oe, 32'h1F);
    rd(KBP_OFF_DATA + 12'h8, 32'h60);
    wr(KBP_OFF_OD, 32'h0);
    ser_clk_oe <= 1'b1;
    ser_clk_o <= 1'b1;
    ser_dout <= 1'b1;
    ext_c <= 7'h04;
    wr(KBP_OFF_FUNC, 32'h1);
    settle();
    chk({c_oe[2:0], c_o[1:0], ser_din}, 32'h1F);
    ser_clk_oe <= 1'b0;
    ext_c <= 7'h01;
    settle();
    chk({ser_clk_i, c_oe[0]}, 32'h2);
    wr(KBP_OFF_DIR + 12'h8, 32'h0);
    tmr_out <= 1'b1;
    wr(KBP_OFF_FUNC, 32'h2);
    chk({c_oe[6], c_o[6]}, 32'h3);
    ext_c <= 7'h40;
    wr(KBP_OFF_FUNC, 32'h0);
    settle();
    chk(tmr_count_in, 32'h1);
    wr(KBP_OFF_IMASK, 32'h1);
    for (int k = 1; k < 4; k++) begin
      wr(KBP_OFF_FUNC, 32'(k << 2));
      ext_c <= 7'h00;
      settle();
      wr(KBP_OFF_ISTAT, 32'h3);
      ext_c <= 7'h40;
      settle();
      rd(KBP_OFF_ISTAT, 32'(k != 2));
      chk(irq, 32'(k != 2));
      wr(KBP_OFF_ISTAT, 32'h3);
      ext_c <= 7'h00;
      settle();
      rd(KBP_OFF_ISTAT, 32'(k != 1));
    end
    wr(KBP_OFF_IMASK, 32'h2);
    chk(irq, 32'h0);
    wr(KBP_OFF_ISTAT, 32'h3);
    ext_d <= 8'hF7;
    settle();
    rd(KBP_OFF_ISTAT, 32'h2);
    chk({irq, keys}, 32'h1F7);
    apb(1'b0, 12'h040, 32'h0, r, e);
    chk(e, 32'h1);
    chk(r, 32'h0);
    final_report();
  end
endmodule // tb
